// ### hdl/sgdma_engine.v
/*
 * Scatter-gather list walker and audio word mover for one pipe.
 * Assumes a simple bus-master port: a read or write request is taken
 * when req and gnt are both high; read data returns later with rvalid
 * in request order. Commands are same-clock one-cycle pulses.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sgdma_consts.vh"

// Summary of operation
// RULE1: A list entry is 8 bytes, the address word first, then the count.
// RULE2: On start the list base is read from the comm page, then parsed.
// RULE3: Cyclic and non-cyclic list modes are both supported.
// RULE4: Non-cyclic mode fetches an entry only while buffer count is nonzero.
// RULE5: The host bumps the buffer count once per complete buffer added.
// RULE6: Cyclic mode ignores the buffer count when fetching.
// RULE7: While count remains, audio moves at the address, count reduces.
// RULE8: A fetch reads 8 bytes, advances the pointer by 8, latches both.
// RULE9: A double-zero entry interrupts and, non-cyclic, drops the count.
// RULE10: Zero count with nonzero address loads the list pointer.
// RULE11: In cyclic mode a double-zero only interrupts.
// RULE12: All audio moves by bus mastering at list addresses.
// RULE13: A 64-bit transfer position is kept for the host.
// RULE14: The host reclaims an entry only once position passes its end.
// RULE15: The host stores entries little-endian.
// RULE16: Stop pauses keeping state; reset command clears it.
// RULE17: A nonzero-count entry loads address and remaining count.
module sgdma_engine #(
    parameter FIFO_DEPTH = `SGDMA_FIFO_DEPTH,
    parameter FIFO_AW    = `SGDMA_FIFO_AW
) (
    input  wire        clk,
    input  wire        reset,
    input  wire        cmd_start,
    input  wire        cmd_stop,
    input  wire        cmd_reset,
    input  wire        cyclic_mode,
    input  wire        direction,
    input  wire [31:0] comm_list_addr,
    input  wire        bump_buffer_count,
    output reg         mem_req,
    output reg         mem_we,
    output reg  [31:0] mem_addr,
    output reg  [31:0] mem_wdata,
    output reg  [1:0]  mem_tag,
    input  wire        mem_gnt,
    input  wire        mem_rvalid,
    input  wire [31:0] mem_rdata,
    input  wire [1:0]  mem_rtag,
    output wire [31:0] play_data,
    output wire        play_valid,
    input  wire        play_ready,
    input  wire [31:0] rec_data,
    input  wire        rec_valid,
    output wire        rec_ready,
    output reg         buffer_irq,
    output wire [63:0] transfer_pos,
    output reg  [31:0] buffer_count,
    output wire        running
);

localparam [6:0] ST_IDLE  = 7'h01;
localparam [6:0] ST_BASE  = 7'h02;
localparam [6:0] ST_RUN   = 7'h04;
localparam [6:0] ST_FADDR = 7'h08;
localparam [6:0] ST_FCNT  = 7'h10;
localparam [6:0] ST_WAIT  = 7'h20;
localparam [6:0] ST_DATA  = 7'h40;

reg  [6:0]  state_reg;
reg  [6:0]  state_next;
reg  [31:0] list_ptr_reg;
reg  [31:0] xfer_addr_reg;
reg  [31:0] remain_reg;
reg  [31:0] ent_addr_reg;
reg         got_cnt_reg;
reg  [31:0] ent_cnt_reg;
reg         active_reg;
reg         based_reg;
reg         pending_reg;
reg         fetch_base_reg;
reg  [31:0] count_next;

wire        fifo_in_valid;
wire        fifo_in_ready;
wire [31:0] fifo_in_data;
wire [31:0] fifo_out_data;
wire        fifo_out_valid;
wire        fifo_out_ready;
wire        req_taken;
wire        rd_data_ret;
wire        ent_done;
wire        dbl_zero;
wire        is_link;
wire        can_fetch;
wire        pos_bump;
reg         pos_clear;

assign running     = active_reg;
assign req_taken   = mem_req && mem_gnt;
assign rd_data_ret = mem_rvalid && (mem_rtag == `SGDMA_TAG_DATA);
assign ent_done    = got_cnt_reg;
assign dbl_zero    = (ent_addr_reg == `SGDMA_ZERO32)
                     && (ent_cnt_reg == `SGDMA_ZERO32);
assign is_link     = (ent_addr_reg != `SGDMA_ZERO32)
                     && (ent_cnt_reg == `SGDMA_ZERO32);
// RULE3 RULE4 RULE6 fetch gate
assign can_fetch   = cyclic_mode || (buffer_count != `SGDMA_ZERO32);

////////////////////////////////////////////////////////////////////////
// Audio FIFO: playback fills from memory, record fills from the port

assign fifo_in_valid  = (direction == `SGDMA_DIR_PLAY) ? rd_data_ret
                                                        : rec_valid;
assign fifo_in_data   = (direction == `SGDMA_DIR_PLAY) ? mem_rdata
                                                        : rec_data;
assign rec_ready      = (direction == `SGDMA_DIR_REC) && fifo_in_ready;
assign play_valid     = (direction == `SGDMA_DIR_PLAY) && fifo_out_valid;
assign play_data      = fifo_out_data;
assign fifo_out_ready = (direction == `SGDMA_DIR_PLAY) ? play_ready
        : (state_reg == ST_RUN && active_reg && mem_req && mem_we
           && mem_gnt);

sgdma_fifo #(
    .WIDTH (32),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .flush     (cmd_reset),
    .in_data   (fifo_in_data),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .level     ()
);

// RULE13 position counter
assign pos_bump = (state_reg == ST_RUN) && req_taken
                  && (mem_tag == `SGDMA_TAG_DATA);

sgdma_pos u_pos (
    .clk      (clk),
    .reset    (reset),
    .clear    (pos_clear),
    .bump     (pos_bump),
    .amount   (`SGDMA_BEAT_BYTES),
    .position (transfer_pos)
);

////////////////////////////////////////////////////////////////////////
// Request and state sequencing

always @* begin
    state_next = state_reg;
    mem_req    = 1'b0;
    mem_we     = 1'b0;
    mem_addr   = xfer_addr_reg;
    mem_wdata  = fifo_out_data;
    mem_tag    = `SGDMA_TAG_DATA;
    pos_clear  = cmd_reset;
    case (state_reg)
        ST_IDLE: begin
            if (active_reg) begin
                state_next = based_reg ? ST_RUN : ST_BASE;
            end
        end
        ST_BASE: begin
            // RULE2 base from comm page
            mem_req  = 1'b1;
            mem_addr = comm_list_addr;
            mem_tag  = `SGDMA_TAG_BASE;
            if (mem_gnt) begin
                state_next = ST_WAIT;
            end
        end
        ST_RUN: begin
            if (!active_reg) begin
                state_next = ST_IDLE;
            end else if (remain_reg != `SGDMA_ZERO32) begin
                // RULE7 RULE12 move one beat, back-pressured by FIFO
                mem_we  = (direction == `SGDMA_DIR_REC);
                // One read in flight, so a return always finds room
                mem_req = mem_we ? fifo_out_valid
                          : (fifo_in_ready && !pending_reg);
            end else if (can_fetch) begin
                state_next = ST_FADDR;
            end
        end
        ST_FADDR: begin
            // RULE1 RULE8 address word first
            mem_req  = 1'b1;
            mem_addr = list_ptr_reg;
            mem_tag  = `SGDMA_TAG_ADDR;
            if (mem_gnt) begin
                state_next = ST_FCNT;
            end
        end
        ST_FCNT: begin
            mem_req  = 1'b1;
            mem_addr = list_ptr_reg + `SGDMA_BEAT_BYTES;
            mem_tag  = `SGDMA_TAG_CNT;
            if (mem_gnt) begin
                state_next = ST_WAIT;
            end
        end
        ST_WAIT: begin
            if (ent_done || (fetch_base_reg && based_reg)) begin
                state_next = ST_DATA;
            end
        end
        ST_DATA: begin
            state_next = ST_RUN;
        end
        default: begin
            state_next = ST_IDLE;
        end
    endcase
    if (cmd_reset) begin
        state_next = ST_IDLE;
    end
end

always @* begin
    count_next = buffer_count;
    if (bump_buffer_count) begin
        count_next = count_next + 32'h0000_0001;
    end
    // RULE9 non-cyclic end of buffer
    if (state_reg == ST_DATA && !fetch_base_reg && dbl_zero
        && !cyclic_mode && count_next != `SGDMA_ZERO32) begin
        count_next = count_next - 32'h0000_0001;
    end
    if (cmd_reset) begin
        count_next = `SGDMA_ZERO32;
    end
end

always @(posedge clk or posedge reset) begin
    if (reset) begin
        state_reg      <= ST_IDLE;
        list_ptr_reg   <= `SGDMA_ZERO32;
        xfer_addr_reg  <= `SGDMA_ZERO32;
        remain_reg     <= `SGDMA_ZERO32;
        ent_addr_reg   <= `SGDMA_ZERO32;
        ent_cnt_reg    <= `SGDMA_ZERO32;
        got_cnt_reg    <= 1'b0;
        active_reg     <= 1'b0;
        based_reg      <= 1'b0;
        pending_reg    <= 1'b0;
        fetch_base_reg <= 1'b0;
        buffer_count   <= `SGDMA_ZERO32;
        buffer_irq     <= 1'b0;
    end else begin
        state_reg    <= state_next;
        buffer_count <= count_next;
        buffer_irq   <= 1'b0;
        // RULE16 stop keeps state, reset clears
        if (cmd_reset) begin
            active_reg <= 1'b0;
            based_reg  <= 1'b0;
            remain_reg <= `SGDMA_ZERO32;
        end else if (cmd_stop) begin
            active_reg <= 1'b0;
        end else if (cmd_start) begin
            active_reg <= 1'b1;
        end
        if (state_reg == ST_BASE && mem_gnt) begin
            fetch_base_reg <= 1'b1;
        end
        if (state_reg == ST_FCNT && mem_gnt) begin
            fetch_base_reg <= 1'b0;
        end
        if (pos_bump && direction == `SGDMA_DIR_PLAY) begin
            pending_reg <= 1'b1;
        end else if (rd_data_ret) begin
            pending_reg <= 1'b0;
        end
        if (mem_rvalid && mem_rtag == `SGDMA_TAG_BASE) begin
            list_ptr_reg <= mem_rdata;
            based_reg    <= 1'b1;
        end
        if (mem_rvalid && mem_rtag == `SGDMA_TAG_ADDR) begin
            ent_addr_reg <= mem_rdata;
        end
        if (mem_rvalid && mem_rtag == `SGDMA_TAG_CNT) begin
            ent_cnt_reg <= mem_rdata;
            got_cnt_reg <= 1'b1;
        end
        if (pos_bump) begin
            xfer_addr_reg <= xfer_addr_reg + `SGDMA_BEAT_BYTES;
            remain_reg    <= (remain_reg > `SGDMA_BEAT_BYTES)
                             ? remain_reg - `SGDMA_BEAT_BYTES
                             : `SGDMA_ZERO32;
        end
        if (state_reg == ST_DATA && !fetch_base_reg) begin
            got_cnt_reg <= 1'b0;
            if (dbl_zero) begin
                // RULE9 RULE11 end-of-buffer interrupt
                buffer_irq   <= 1'b1;
                list_ptr_reg <= list_ptr_reg + `SGDMA_ENTRY_BYTES;
            end else if (is_link) begin
                // RULE10 link entry
                list_ptr_reg <= ent_addr_reg;
            end else begin
                // RULE17 RULE8 load block and advance
                list_ptr_reg  <= list_ptr_reg + `SGDMA_ENTRY_BYTES;
                xfer_addr_reg <= ent_addr_reg;
                remain_reg    <= ent_cnt_reg;
            end
        end
        if (state_reg == ST_DATA && fetch_base_reg) begin
            fetch_base_reg <= 1'b0;
        end
    end
end

endmodule
`default_nettype wire

// ### include/sgdma_consts.vh
/*
 * Constants for the scatter-gather audio transfer engine.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef SGDMA_CONSTS_VH
`define SGDMA_CONSTS_VH

// List entry layout: address word first, count word second
`define SGDMA_ENTRY_BYTES   32'h0000_0008
`define SGDMA_ADDR_W        32
`define SGDMA_POS_W         64
`define SGDMA_ZERO32        32'h0000_0000
`define SGDMA_ZERO64        64'h0000_0000_0000_0000
// Bytes moved per audio word beat
`define SGDMA_BEAT_BYTES    32'h0000_0004
// Memory read tags
`define SGDMA_TAG_ADDR      2'h0
`define SGDMA_TAG_CNT       2'h1
`define SGDMA_TAG_DATA      2'h2
`define SGDMA_TAG_BASE      2'h3
// Transfer direction
`define SGDMA_DIR_PLAY      1'b0
`define SGDMA_DIR_REC       1'b1
// Default buffering
`define SGDMA_FIFO_DEPTH    16
`define SGDMA_FIFO_AW       4

`endif

// ### hdl/sgdma_fifo.v
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock; width and depth are parameters, depth a power of 2.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sgdma_consts.vh"

module sgdma_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = `SGDMA_FIFO_DEPTH,
    parameter AW    = `SGDMA_FIFO_AW
) (
    input  wire             clk,
    input  wire             reset,
    input  wire             flush,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [AW:0]      level
);

reg  [WIDTH-1:0] mem [0:DEPTH-1];
reg  [AW:0]      wr_reg;
reg  [AW:0]      rd_reg;
wire             push;
wire             pop;

assign level     = wr_reg - rd_reg;
// Full when the pointers differ only in their wrap bit
assign in_ready  = (wr_reg[AW] == rd_reg[AW])
                   || (wr_reg[AW-1:0] != rd_reg[AW-1:0]);
assign out_valid = (wr_reg != rd_reg);
assign out_data  = mem[rd_reg[AW-1:0]];
assign push      = in_valid && in_ready;
assign pop       = out_valid && out_ready;

always @(posedge clk) begin
    if (push) begin
        mem[wr_reg[AW-1:0]] <= in_data;
    end
end

always @(posedge clk or posedge reset) begin
    if (reset) begin
        wr_reg <= {(AW+1){1'b0}};
        rd_reg <= {(AW+1){1'b0}};
    end else if (flush) begin
        wr_reg <= {(AW+1){1'b0}};
        rd_reg <= {(AW+1){1'b0}};
    end else begin
        if (push) begin
            wr_reg <= wr_reg + {{AW{1'b0}}, 1'b1};
        end
        if (pop) begin
            rd_reg <= rd_reg + {{AW{1'b0}}, 1'b1};
        end
    end
end

endmodule
`default_nettype wire

// ### hdl/sgdma_pos.v
/*
 * 64-bit transfer position counter for one pipe.
 * Assumes increments come from the engine on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sgdma_consts.vh"

module sgdma_pos (
    input  wire        clk,
    input  wire        reset,
    input  wire        clear,
    input  wire        bump,
    input  wire [31:0] amount,
    output reg  [63:0] position
);

always @(posedge clk or posedge reset) begin
    if (reset) begin
        position <= `SGDMA_ZERO64;
    end else if (clear) begin
        position <= `SGDMA_ZERO64;
    end else if (bump) begin
        position <= position + {32'h0000_0000, amount};
    end
end

endmodule
`default_nettype wire

// ### sim/sgdma_engine_checker.sv
/*
 * Port assertions for the list-walking audio engine.
 * Assumes binding onto sgdma_engine, one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sgdma_consts.vh"

module sgdma_engine_checker (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        cmd_reset,
    input wire logic        cmd_stop,
    input wire logic        cyclic_mode,
    input wire logic        direction,
    input wire logic [31:0] comm_list_addr,
    input wire logic        bump_buffer_count,
    input wire logic        mem_req,
    input wire logic        mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [1:0]  mem_tag,
    input wire logic        mem_gnt,
    input wire logic        buffer_irq,
    input wire logic [63:0] transfer_pos,
    input wire logic [31:0] buffer_count
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
////////////////////////////////////////////////////////////////////////////
    a_req_held_stable: assert property (
        mem_req && !mem_gnt && !cmd_reset && !cmd_stop |=>
        mem_req && $stable(mem_addr) && $stable(mem_tag))
        else $error("request changed before grant");
    a_base_read_addr: assert property (
        mem_req && mem_tag == `SGDMA_TAG_BASE |->
        !mem_we && mem_addr == comm_list_addr)
        else $error("list base read wrong");
    a_nc_fetch_gated: assert property (
        !cyclic_mode && buffer_count == `SGDMA_ZERO32 |->
        !(mem_req && mem_tag == `SGDMA_TAG_ADDR))
        else $error("entry fetched at zero count");
    a_cyc_count_kept: assert property (
        cyclic_mode && !bump_buffer_count && !cmd_reset |=>
        buffer_count == $past(buffer_count))
        else $error("cyclic mode changed count");
    a_nc_irq_drop: assert property (
        buffer_irq && !cyclic_mode && !$past(bump_buffer_count)
        && !$past(cmd_reset)
        && $past(buffer_count) != `SGDMA_ZERO32 |->
        buffer_count == $past(buffer_count) - 32'h0000_0001)
        else $error("count not dropped at buffer end");
    a_irq_one_cycle: assert property (
        buffer_irq |=> !buffer_irq)
        else $error("irq longer than a cycle");
    a_pos_step_four: assert property (
        !cmd_reset |=> transfer_pos == $past(transfer_pos)
        || transfer_pos == $past(transfer_pos) + 64'h0000_0000_0000_0004)
        else $error("position step wrong");
    a_data_dir_match: assert property (
        mem_req && mem_tag == `SGDMA_TAG_DATA |-> mem_we == direction)
        else $error("audio access direction wrong");
    c_irq_cyclic: cover property (buffer_irq && cyclic_mode);
    c_irq_noncyc: cover property (buffer_irq && !cyclic_mode);
    c_rec_write: cover property (mem_req && mem_gnt && mem_we);
endmodule

bind sgdma_engine sgdma_engine_checker sgdma_engine_checker_inst (
    .clk(clk), .reset(reset), .cmd_reset(cmd_reset), .cmd_stop(cmd_stop),
    .cyclic_mode(cyclic_mode), .direction(direction),
    .comm_list_addr(comm_list_addr), .bump_buffer_count(bump_buffer_count),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_tag(mem_tag), .mem_gnt(mem_gnt), .buffer_irq(buffer_irq),
    .transfer_pos(transfer_pos), .buffer_count(buffer_count)
);
`default_nettype wire

// ### sim/sgdma_host_mem.sv
/*
 * Host memory model answering the engine's bus-master port.
 * Assumes in-order returns; stall slows both grants and returns.
 */
`timescale 1ns/1ps
`default_nettype none

module sgdma_host_mem (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        stall,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [31:0] mem_addr,
    input  wire logic [31:0] mem_wdata,
    input  wire logic [1:0]  mem_tag,
    output logic             mem_gnt,
    output logic             mem_rvalid,
    output logic [31:0]      mem_rdata,
    output logic [1:0]       mem_rtag
);
    logic [31:0] words [0:255];
    logic [33:0] pend [$];
////////////////////////////////////////////////////////////////////////////
    // grant the master
    assign mem_gnt = !stall;
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            mem_rvalid <= 1'b0;
            mem_rdata  <= 32'hA5A5_5A5A;
            mem_rtag   <= 2'h0;
            pend.delete();
        end else begin
            // Idle bus toggles so stale data is never mistaken
            mem_rvalid <= 1'b0;
            if (pend.size() > 0 && !stall) begin
                mem_rvalid <= 1'b1;
                {mem_rtag, mem_rdata} <= pend.pop_front();
            end else
                mem_rdata <= ~mem_rdata;
            if (mem_req && mem_gnt && mem_we)
                words[mem_addr[9:2]] <= mem_wdata;
            else if (mem_req && mem_gnt)
                pend.push_back({mem_tag, words[mem_addr[9:2]]});
        end
    end
endmodule
`default_nettype wire

// ### sim/sg_list_audio_dma_tb.sv
/*
 * Self-checking bench of the list-walking audio engine.
 * Assumes the host memory model and the bound checker.
 */
`timescale 1ns/1ps
`default_nettype none

module sg_list_audio_dma_tb;
    localparam logic [31:0] A0 = 32'h1234_ABCD, A1 = 32'h9ABC_0F0F;
    localparam logic [31:0] R0 = 32'h5000_0001, R1 = 32'h5000_0002;
    localparam logic [31:0] R2 = 32'h5000_0003, R3 = 32'h5000_0004;
    logic        clk = 1'b0, reset = 1'b1, cyc = 1'b0, dir = 1'b0;
    logic        p_rdy = 1'b0, r_vld = 1'b0, stall = 1'b0;
    logic [3:0]  cmd = 4'h0;
    logic [31:0] r_dat = 32'h0, list_ptr = 32'h0000_0040;
    logic        mem_req, mem_we, mem_gnt, mem_rvalid;
    logic        play_valid, rec_ready, buffer_irq, running;
    logic [1:0]  mem_tag, mem_rtag;
    logic [31:0] mem_addr, mem_wdata, mem_rdata, play_data, buffer_count;
    logic [63:0] transfer_pos;
    int          bad_count = 0, num_checks = 0, irqs = 0, cycles = 0;

    always #2 clk = ~clk;
    sgdma_engine sgdma_engine_inst (
        .clk(clk), .reset(reset), .cmd_start(cmd[0]), .cmd_stop(cmd[1]),
        .cmd_reset(cmd[2]), .cyclic_mode(cyc), .direction(dir),
        .comm_list_addr(list_ptr), .bump_buffer_count(cmd[3]),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_tag(mem_tag), .mem_gnt(mem_gnt),
        .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .mem_rtag(mem_rtag),
        .play_data(play_data), .play_valid(play_valid), .play_ready(p_rdy),
        .rec_data(r_dat), .rec_valid(r_vld), .rec_ready(rec_ready),
        .buffer_irq(buffer_irq), .transfer_pos(transfer_pos),
        .buffer_count(buffer_count), .running(running));
    sgdma_host_mem sgdma_host_mem_inst (
        .clk(clk), .reset(reset), .stall(stall), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_tag(mem_tag), .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid),
        .mem_rdata(mem_rdata), .mem_rtag(mem_rtag));
////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (buffer_irq === 1'b1)
            irqs <= irqs + 1;
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            bad_count++;
            stop_test();
        end
    end

    task automatic check(input string what, input logic [63:0] exp,
                         input logic [63:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask

    task automatic pulse(input logic [3:0] v);
        @(negedge clk);
        cmd = v;
        @(negedge clk);
        cmd = 4'h0;
    endtask

    task automatic take(input logic [31:0] exp);
        int n;
        n = 0;
        @(negedge clk);
        p_rdy = 1'b1;
        while (play_valid !== 1'b1 && n < 500) begin
            @(negedge clk);
            n++;
        end
        check("play valid", 1, play_valid);
        check("play word", {32'h0, exp}, {32'h0, play_data});
        @(negedge clk);
        p_rdy = 1'b0;
    endtask

    task automatic push(input logic [31:0] d);
        int n;
        n = 0;
        @(negedge clk);
        r_dat = d;
        r_vld = 1'b1;
        while (rec_ready !== 1'b1 && n < 500) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        r_vld = 1'b0;
    endtask

    task automatic test_cyclic();
        int i;
        cyc = 1'b1;
        pulse(4'h1);
        take(A0);
        take(A1);
        repeat (300) @(negedge clk);
        stall = 1'b1;
        check("irqs", 1, irqs > 4);
        check("count", 0, buffer_count);
        for (i = 0; i < 16; i++)
            take(i % 2 ? A1 : A0);
        repeat (4) @(negedge clk);
        check("drained", 0, play_valid);
        check("position", 64'h48, transfer_pos);
        pulse(4'h2);
        pulse(4'h4);
        stall = 1'b0;
        repeat (4) @(negedge clk);
        check("cleared", 0, transfer_pos);
        $display("test cyclic done");
    endtask

    task automatic test_noncyclic();
        int i, k;
        cyc = 1'b0;
        pulse(4'h1);
        repeat (40) @(negedge clk);
        check("idle", 0, play_valid);
        k = irqs;
        pulse(4'h8);
        take(A0);
        take(A1);
        repeat (40) @(negedge clk);
        check("irq", k + 1, irqs);
        check("count", 0, buffer_count);
        check("held", 0, play_valid);
        check("reclaim wait", 0, transfer_pos > 64'h8);
        pulse(4'h8);
        pulse(4'h8);
        for (i = 0; i < 4; i++)
            take(i % 2 ? A1 : A0);
        repeat (40) @(negedge clk);
        check("irqs", k + 3, irqs);
        check("reclaimable", 1, transfer_pos > 64'h8);
        check("count", 0, buffer_count);
        pulse(4'h2);
        pulse(4'h4);
        $display("test noncyclic done");
    endtask

    task automatic test_record();
        cyc = 1'b1;
        dir = 1'b1;
        pulse(4'h1);
        push(R0);
        push(R1);
        repeat (40) @(negedge clk);
        check("word0", R0, sgdma_host_mem_inst.words[8'h80]);
        check("word1", R1, sgdma_host_mem_inst.words[8'h81]);
        pulse(4'h2);
        check("stopped", 0, running);
        push(R2);
        repeat (40) @(negedge clk);
        check("paused", 64'h8, transfer_pos);
        pulse(4'h1);
        push(R3);
        repeat (40) @(negedge clk);
        check("wrap0", R2, sgdma_host_mem_inst.words[8'h80]);
        check("wrap1", R3, sgdma_host_mem_inst.words[8'h81]);
        check("position", 64'h10, transfer_pos);
        $display("test record done");
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic poke(input logic [7:0] i, input logic [31:0] v);
        sgdma_host_mem_inst.words[i] = v;
    endtask

    initial begin
        poke(8'h10, 32'h0000_0100);
        poke(8'h40, 32'h0000_0200);
        poke(8'h41, 32'h0000_0008);
        poke(8'h42, 32'h0000_0000);
        poke(8'h43, 32'h0000_0000);
        poke(8'h44, 32'h0000_0100);
        poke(8'h45, 32'h0000_0000);
        poke(8'h80, A0);
        poke(8'h81, A1);
        repeat (3) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        test_cyclic();
        test_noncyclic();
        test_record();
        stop_test();
    end
endmodule
`default_nettype wire
